// >>> core/eq_dfe.sv
// Adaptive decision-feedback equalizer with register port and coefficient access
`include "eq_regs.svh"

// Operation
// RULE1: 64 feed-forward plus 192 feedback taps
// RULE2: every tap updates within one symbol
// RULE3: output is feed-forward plus feedback sum
// RULE4: forward takes input, feedback takes training/decisions
// RULE5: coefficient plus error times data times step
// RULE6: error against training, else against slicer (blind mode here uses a coarse two-level decision instead of the slicer)
// RULE7: adapt on training, open-eye data, blind
// RULE8: one multiplier serves four taps
// RULE9: hold bit low forces error zero
// RULE10: init bit set reloads initial coefficients
// RULE11: step field selects small, middle, large
// RULE12: decision-directed off bit stops data adaptation
// RULE13: bit seven turns feedback off in 16-level
// RULE14: bit six limits feedback to 8-level
// RULE15: input and output mean squared error readable
// RULE16: centre tap position is programmable
// RULE17: works in all five VSB modes
// RULE18: host holds, writes index, coefficient, strobes
// RULE19: host holds, writes index, strobes, reads coefficient
// RULE20: slicer picks nearest level of active constellation
module eq_dfe (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire eq_pkg::eq_in_s in_s,
    input wire logic train_active,
    input wire logic train_bit,
    input wire logic [2:0] vsb_mode,
    input wire eq_pkg::eq_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    output eq_pkg::eq_out_s out_s,
    output logic tracker_hold_n,
    output eq_pkg::eq_adapt_e adapt_mode
);
    localparam int NTAP = 256;
    localparam int NFF = 64;
    localparam int NMUL = 64;

    // Register state
    logic [7:0] ctrl_r;
    logic [7:0] aux_r;
    logic [7:0] fbsel_r;
    logic [7:0] center_r;
    logic [7:0] tap_index_r;
    logic [15:0] coef_write_value_r;
    logic [15:0] coef_read_value_r;
    logic strobe_q_r;
    logic [15:0] mse_in_r;
    logic [15:0] mse_out_r;

    // Datapath state
    eq_pkg::eq_sym_t tap_d [NTAP];
    eq_pkg::eq_coef_t coef [NTAP];
    logic busy_r;
    logic [1:0] phase_r;
    logic signed [31:0] acc_r;
    logic signed [11:0] err_r;
    eq_pkg::eq_sym_t dec_r;

    logic eq_hold_n;
    logic eq_coef_init;
    logic [1:0] lms_step_select;
    logic decision_directed_off;
    logic coef_access_dir;
    logic coef_transfer_strobe_n;
    logic fb_off_sixteen_level;
    logic fb_limit_eight_level;
    logic fb_on;
    logic [3:0] step_shift;
    logic accept;
    logic pass_end;
    logic strobe_fall;
    logic signed [31:0] grp_sum;
    logic signed [31:0] y_full;
    logic signed [15:0] y_sat;
    logic signed [9:0] max_lvl;
    eq_pkg::eq_sym_t dec_nxt;
    eq_pkg::eq_sym_t ref_nxt;
    logic signed [11:0] err_nxt;
    logic signed [11:0] in_err;
    logic signed [11:0] out_err;
    eq_pkg::eq_adapt_e mode_nxt;

    assign eq_hold_n = ctrl_r[`EQ_BIT_HOLD];
    assign eq_coef_init = ctrl_r[`EQ_BIT_INIT];
    assign lms_step_select = ctrl_r[`EQ_STEP_HI:`EQ_STEP_LO];
    assign decision_directed_off = aux_r[`EQ_BIT_DD_OFF];
    assign coef_access_dir = aux_r[`EQ_BIT_DIR];
    assign coef_transfer_strobe_n = aux_r[`EQ_BIT_STROBE];
    assign fb_off_sixteen_level = fbsel_r[`EQ_BIT_FB_OFF16];
    assign fb_limit_eight_level = fbsel_r[`EQ_BIT_FB_LIMIT];

    // Slicer: nearest odd level, clamped to the outermost level of the mode
    function automatic eq_pkg::eq_sym_t eq_slice(input logic signed [15:0] y, input logic signed [9:0] mx);
        logic signed [15:0] q;
        q = ((y >>> (`EQ_LVL_SH + 1)) <<< 1) + 16'sh0001;
        if (q > 16'(mx)) begin
            q = 16'(mx);
        end else if (q < -16'(mx)) begin
            q = -16'(mx);
        end
        return 10'(q <<< `EQ_LVL_SH);
    endfunction

    // Error saturated to the error width so that a wild output cannot wrap its sign
    function automatic logic signed [11:0] eq_err_sat(input logic signed [15:0] e);
        if (e > 16'sh07ff) begin
            return 12'sh7ff;
        end else if (e < -16'sh0800) begin
            return -12'sh800;
        end
        return 12'(e);
    endfunction

    // Outermost level of the active constellation; unknown codes fall back to 8-level
    always_comb begin
        unique case (vsb_mode)
            `EQ_VSB2: max_lvl = 10'sh001; // RULE17 RULE20
            `EQ_VSB4: max_lvl = 10'sh003;
            `EQ_VSB16: max_lvl = 10'sh00f;
            default: max_lvl = 10'sh007;
        endcase
    end

    // Feedback section enable per constellation
    always_comb begin
        if (vsb_mode == `EQ_VSB16) begin
            fb_on = !fb_off_sixteen_level; // RULE13
        end else if (vsb_mode == `EQ_VSB8 || vsb_mode == `EQ_VSB8T) begin
            fb_on = 1'b1; // RULE14
        end else begin
            fb_on = !fb_limit_eight_level; // RULE14
        end
    end

    // Step field decode, two codes share the smallest step
    always_comb begin
        unique case (lms_step_select)
            2'b10: step_shift = `EQ_SHIFT_MID; // RULE11
            2'b11: step_shift = `EQ_SHIFT_LARGE;
            default: step_shift = `EQ_SHIFT_SMALL;
        endcase
    end

    // A new symbol is taken when idle or in the last quarter of a pass, so one per four clocks
    assign accept = in_s.valid && (!busy_r || phase_r == `EQ_LAST_PHASE);
    assign pass_end = busy_r && phase_r == `EQ_LAST_PHASE;
    assign strobe_fall = strobe_q_r && !coef_transfer_strobe_n;

    // Shared multipliers: this quarter's taps are 4k+phase
    always_comb begin
        logic [7:0] j;
        logic signed [25:0] p;
        grp_sum = 32'sh0000_0000;
        j = 8'h00;
        p = 26'sh0;
        for (int k = 0; k < NMUL; k++) begin
            j = 8'({k[5:0], phase_r}); // RULE8
            p = coef[j] * tap_d[j];
            if (j >= 8'(NFF) && !fb_on) begin
                p = 26'sh0;
            end
            grp_sum = grp_sum + 32'(p);
        end
    end

    // Forward and feedback products land in one accumulator, so the output is their sum
    assign y_full = (acc_r + grp_sum) >>> `EQ_COEF_FRAC; // RULE3
    assign y_sat = (y_full > 32'sh0000_7fff) ? 16'sh7fff : (y_full < -32'sh0000_8000) ? -16'sh8000 : 16'(y_full);
    assign dec_nxt = eq_slice(y_sat, max_lvl); // RULE20
    assign in_err = eq_err_sat(16'(in_s.sym) - 16'(eq_slice(16'(in_s.sym), max_lvl)));
    assign out_err = eq_err_sat($signed(out_s.sym) - 16'(eq_slice(out_s.sym, max_lvl)));

    // Adaptation mode: hold wins, then training; data mode only while the eye looks open
    always_comb begin
        if (!eq_hold_n) begin
            mode_nxt = eq_pkg::EQ_ADAPT_NONE;
        end else if (train_active) begin
            mode_nxt = eq_pkg::EQ_ADAPT_TRAIN; // RULE7
        end else if (mse_out_r < `EQ_EYE_THRESH) begin
            mode_nxt = decision_directed_off ? eq_pkg::EQ_ADAPT_NONE : eq_pkg::EQ_ADAPT_DATA; // RULE12
        end else begin
            mode_nxt = eq_pkg::EQ_ADAPT_BLIND; // RULE7
        end
    end

    // Reference for the error; blind uses a coarse two-level decision
    always_comb begin
        unique case (mode_nxt)
            eq_pkg::EQ_ADAPT_TRAIN: ref_nxt = train_bit ? `EQ_TRAIN_LVL : -`EQ_TRAIN_LVL; // RULE6
            eq_pkg::EQ_ADAPT_DATA: ref_nxt = dec_nxt; // RULE6
            eq_pkg::EQ_ADAPT_BLIND: ref_nxt = 10'((y_sat < 16'sh0000) ? -((max_lvl + 10'sh001) <<< (`EQ_LVL_SH - 1))
                                                                   : ((max_lvl + 10'sh001) <<< (`EQ_LVL_SH - 1)));
            eq_pkg::EQ_ADAPT_NONE: ref_nxt = 10'(y_sat);
        endcase
    end

    // Forced to zero when held, or when decision-directed off meets an open eye outside training, so the coefficients cannot move
    assign err_nxt = (mode_nxt == eq_pkg::EQ_ADAPT_NONE) ? 12'sh000 : eq_err_sat(16'(ref_nxt) - y_sat); // RULE9

    // Pass sequencing: four quarters per symbol
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_r <= 1'b0;
            phase_r <= 2'h0;
        end else if (ce) begin
            if (accept) begin
                busy_r <= 1'b1;
                phase_r <= 2'h0;
            end else if (pass_end) begin
                busy_r <= 1'b0;
                phase_r <= 2'h0;
            end else if (busy_r) begin
                phase_r <= phase_r + 2'h1;
            end
        end
    end

    // Accumulator sums every quarter; output, decision and error are latched at the end of each pass
    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_r <= 32'sh0000_0000;
            out_s <= '0;
            err_r <= 12'sh000;
            dec_r <= 10'sh000;
            adapt_mode <= eq_pkg::EQ_ADAPT_NONE;
        end else if (ce) begin
            out_s.valid <= pass_end;
            if (busy_r) begin
                acc_r <= (phase_r == 2'h0) ? grp_sum : acc_r + grp_sum;
            end
            if (pass_end) begin
                out_s.sym <= y_sat; // RULE3
                err_r <= err_nxt; // RULE6
                dec_r <= dec_nxt;
                adapt_mode <= mode_nxt;
            end
        end
    end

    // Delay lines: forward gets input symbols, feedback gets training or decisions
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NTAP; i++) begin
                tap_d[i] <= 10'sh000;
            end
        end else if (ce && accept) begin
            tap_d[0] <= in_s.sym; // RULE4
            for (int i = 1; i < NFF; i++) begin
                tap_d[i] <= tap_d[i - 1]; // RULE1
            end
            tap_d[NFF] <= (adapt_mode == eq_pkg::EQ_ADAPT_TRAIN) ? (train_bit ? `EQ_TRAIN_LVL : -`EQ_TRAIN_LVL)
                                                                : dec_r; // RULE4
            for (int i = NFF + 1; i < NTAP; i++) begin
                tap_d[i] <= tap_d[i - 1]; // RULE1
            end
        end
    end

    // Coefficients: init places unity at the centre tap; each quarter updates its 64 taps
    always_ff @(posedge core_clk) begin
        logic [7:0] j;
        logic signed [21:0] pr;
        j = 8'h00;
        pr = 22'sh0;
        if (rst || (ce && eq_coef_init)) begin
            for (int i = 0; i < NTAP; i++) begin
                coef[i] <= (8'(i) == center_r) ? `EQ_COEF_UNITY : 16'sh0000; // RULE10 RULE16
            end
        end else if (ce) begin
            // Gated here too, since err_r may still carry the error of the pass before the hold
            if (busy_r && eq_hold_n) begin // RULE9
                for (int k = 0; k < NMUL; k++) begin
                    j = 8'({k[5:0], phase_r});
                    pr = err_r * tap_d[j];
                    if (j < 8'(NFF) || fb_on) begin
                        coef[j] <= coef[j] + 16'(pr >>> step_shift); // RULE2 RULE5
                    end
                end
            end
            // Host write wins over adaptation; the host is expected to hold first
            if (strobe_fall && coef_access_dir) begin
                coef[tap_index_r] <= coef_write_value_r; // RULE18
            end
        end
    end

    // Mean squared error, leaky average of squared error at input and output
    always_ff @(posedge core_clk) begin
        logic [23:0] sq_in;
        logic [23:0] sq_out;
        sq_in = 24'(in_err) * 24'(in_err);
        sq_out = 24'(out_err) * 24'(out_err);
        if (rst) begin
            mse_in_r <= 16'h0000;
            mse_out_r <= 16'h0000;
        end else if (ce) begin
            if (accept) begin
                mse_in_r <= mse_in_r - (mse_in_r >> `EQ_MSE_SH) + 16'(sq_in >> `EQ_MSE_SH); // RULE15
            end
            if (out_s.valid) begin
                mse_out_r <= mse_out_r - (mse_out_r >> `EQ_MSE_SH) + 16'(sq_out >> `EQ_MSE_SH); // RULE15
            end
        end
    end

    // Register writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= `EQ_CTRL_RST;
            aux_r <= `EQ_AUX_RST;
            fbsel_r <= `EQ_FBSEL_RST;
            center_r <= `EQ_CENTER_RST;
            tap_index_r <= 8'h00;
            coef_write_value_r <= 16'h0000;
            strobe_q_r <= 1'b1;
            tracker_hold_n <= 1'b1;
        end else if (ce) begin
            strobe_q_r <= coef_transfer_strobe_n;
            tracker_hold_n <= ctrl_r[`EQ_BIT_TRK_HOLD];
            if (reg_req.we) begin
                unique case (reg_req.addr)
                    `EQ_ADDR_CTRL: ctrl_r <= reg_req.wdata; // RULE9 RULE10 RULE11
                    `EQ_ADDR_AUX: aux_r <= reg_req.wdata; // RULE12
                    `EQ_ADDR_FBSEL: fbsel_r <= reg_req.wdata; // RULE13 RULE14
                    `EQ_ADDR_CENTER: center_r <= reg_req.wdata; // RULE16
                    `EQ_ADDR_TAP: tap_index_r <= reg_req.wdata;
                    `EQ_ADDR_COEF_HI: coef_write_value_r[15:8] <= reg_req.wdata;
                    `EQ_ADDR_WR_LO: coef_write_value_r[7:0] <= reg_req.wdata;
                    default: ;
                endcase
            end
        end
    end

    // Read capture on the falling edge of the transfer strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            coef_read_value_r <= 16'h0000;
        end else if (ce && strobe_fall && !coef_access_dir) begin
            coef_read_value_r <= coef[tap_index_r]; // RULE19
        end
    end

    // Register reads, unmapped addresses read zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            unique case (reg_req.addr)
                `EQ_ADDR_CTRL: reg_rdata <= ctrl_r;
                `EQ_ADDR_AUX: reg_rdata <= aux_r;
                `EQ_ADDR_FBSEL: reg_rdata <= fbsel_r;
                `EQ_ADDR_CENTER: reg_rdata <= center_r;
                `EQ_ADDR_TAP: reg_rdata <= tap_index_r;
                `EQ_ADDR_COEF_HI: reg_rdata <= coef_access_dir ? coef_write_value_r[15:8] : coef_read_value_r[15:8];
                `EQ_ADDR_WR_LO: reg_rdata <= coef_write_value_r[7:0];
                `EQ_ADDR_RD_LO: reg_rdata <= coef_read_value_r[7:0];
                `EQ_ADDR_MSE_IN: reg_rdata <= mse_in_r[15:8]; // RULE15
                `EQ_ADDR_MSE_OUT: reg_rdata <= mse_out_r[15:8]; // RULE15
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// >>> core/eq_regs.svh
// Register addresses, field positions, reset values and scaling constants of the equalizer
`ifndef EQ_DFE_REGS_SVH
`define EQ_DFE_REGS_SVH

`define EQ_ADDR_CTRL 8'h21
`define EQ_ADDR_AUX 8'h22
`define EQ_ADDR_FBSEL 8'h23
`define EQ_ADDR_CENTER 8'h24
`define EQ_ADDR_TAP 8'h25
`define EQ_ADDR_COEF_HI 8'h26
`define EQ_ADDR_WR_LO 8'h27
`define EQ_ADDR_RD_LO 8'h28
`define EQ_ADDR_MSE_IN 8'h29
`define EQ_ADDR_MSE_OUT 8'h2a

`define EQ_CTRL_RST 8'h8b
`define EQ_AUX_RST 8'h04
`define EQ_FBSEL_RST 8'h80
`define EQ_CENTER_RST 8'h10

`define EQ_BIT_TRK_HOLD 7
`define EQ_BIT_HOLD 3
`define EQ_BIT_INIT 2
`define EQ_STEP_HI 1
`define EQ_STEP_LO 0
`define EQ_BIT_DD_OFF 0
`define EQ_BIT_DIR 1
`define EQ_BIT_STROBE 2
`define EQ_BIT_FB_OFF16 7
`define EQ_BIT_FB_LIMIT 6

`define EQ_SHIFT_SMALL 4'hc
`define EQ_SHIFT_MID 4'ha
`define EQ_SHIFT_LARGE 4'h8
`define EQ_COEF_UNITY 16'h1000
`define EQ_COEF_FRAC 12
`define EQ_LVL_SH 5
`define EQ_TRAIN_LVL 10'h0a0
`define EQ_MSE_SH 6
`define EQ_EYE_THRESH 16'h0400
`define EQ_LAST_PHASE 2'h3

`define EQ_VSB2 3'h0
`define EQ_VSB4 3'h1
`define EQ_VSB8 3'h2
`define EQ_VSB16 3'h4
`define EQ_VSB8T 3'h5

`endif

// >>> core/eq_pkg.sv
// Types shared by the equalizer and its surroundings
package eq_pkg;
    typedef logic signed [9:0] eq_sym_t;
    typedef logic signed [15:0] eq_coef_t;

    typedef struct packed {
        logic valid;
        eq_sym_t sym;
    } eq_in_s;

    typedef struct packed {
        logic valid;
        logic signed [15:0] sym;
    } eq_out_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
    } eq_reg_req_s;

    typedef enum logic [1:0] {
        EQ_ADAPT_TRAIN = 2'b00,
        EQ_ADAPT_DATA = 2'b01,
        EQ_ADAPT_BLIND = 2'b10,
        EQ_ADAPT_NONE = 2'b11
    } eq_adapt_e;
endpackage

// >>> test/eq_sync_model.sv
// Upstream symbol source standing in for the synchronizer
module eq_sync_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic slow,
    input wire eq_pkg::eq_sym_t sym_in,
    output eq_pkg::eq_in_s in_s
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt;
    logic nv;

    // One symbol every four clocks, or every eight when slow
    assign nv = slow ? (cnt == 3'h7) : (cnt[1:0] == 2'h3);

    // Between symbols the data lines carry the inverse, so stale values are never mistaken for data
    always @(negedge core_clk) begin
        if (rst || !run) begin
            cnt <= 3'h0;
            in_s <= '0;
        end else begin
            cnt <= cnt + 3'h1;
            in_s <= {nv, nv ? sym_in : ~sym_in};
        end
    end
endmodule

// >>> test/eq_dfe_checker.sv
// Port-level assertions for the equalizer, bound to its top module
`include "eq_regs.svh"
module eq_dfe_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire eq_pkg::eq_in_s in_s,
    input wire logic train_active,
    input wire logic train_bit,
    input wire logic [2:0] vsb_mode,
    input wire eq_pkg::eq_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire eq_pkg::eq_out_s out_s,
    input wire logic tracker_hold_n,
    input wire eq_pkg::eq_adapt_e adapt_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Decoded writes to plain read-write registers
    logic ctrl_wr;
    logic rw_wr;
    assign ctrl_wr = ce && reg_req.we && reg_req.addr == `EQ_ADDR_CTRL;
    assign rw_wr = ce && reg_req.we && reg_req.addr inside {`EQ_ADDR_CTRL, `EQ_ADDR_FBSEL, `EQ_ADDR_CENTER};

    sequence s_rw_write;
        rw_wr;
    endsequence
    sequence s_same_read;
        ce && !reg_req.we && reg_req.addr == $past(reg_req.addr);
    endsequence

    property p_rst_out;
        disable iff (1'b0)
        rst |=> (out_s == '0 && reg_rdata == 8'h00 && tracker_hold_n && adapt_mode == eq_pkg::EQ_ADAPT_NONE);
    endproperty
    property p_rw_readback;
        s_rw_write ##1 s_same_read |=> reg_rdata == $past(reg_req.wdata, 2);
    endproperty
    property p_trk_follow;
        ctrl_wr |-> ##2 tracker_hold_n == $past(reg_req.wdata[`EQ_BIT_TRK_HOLD], 2);
    endproperty
    property p_trk_cause;
        $changed(tracker_hold_n) |-> $past(ctrl_wr, 2);
    endproperty
    // Addresses outside the map always read as zero
    property p_unmapped;
        ce && (reg_req.addr < `EQ_ADDR_CTRL || reg_req.addr > `EQ_ADDR_MSE_OUT) |=> reg_rdata == 8'h00;
    endproperty
    property p_out_latency;
        out_s.valid |-> $past(in_s.valid, 5);
    endproperty
    property p_out_pulse;
        out_s.valid |=> !out_s.valid [*3];
    endproperty
    property p_sym_stands;
        !out_s.valid |-> $stable(out_s.sym);
    endproperty

    a_rst_out: assert property (p_rst_out) else $error("outputs not at reset values");
    a_rw_readback: assert property (p_rw_readback) else $error("register readback differs");
    a_trk_follow: assert property (p_trk_follow) else $error("tracker hold not following control");
    a_trk_cause: assert property (p_trk_cause) else $error("tracker hold moved without a write");
    a_unmapped: assert property (p_unmapped) else $error("unmapped address read nonzero");
    a_out_latency: assert property (p_out_latency) else $error("output without a symbol five clocks before");
    a_out_pulse: assert property (p_out_pulse) else $error("outputs closer than four clocks");
    a_sym_stands: assert property (p_sym_stands) else $error("output changed without valid");
endmodule

bind eq_dfe eq_dfe_checker u_chk (.core_clk(core_clk), .rst(rst), .ce(ce), .in_s(in_s),
    .train_active(train_active), .train_bit(train_bit), .vsb_mode(vsb_mode), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .out_s(out_s), .tracker_hold_n(tracker_hold_n), .adapt_mode(adapt_mode));

// >>> test/tb_top.sv
// Self-checking bench: register map, coefficient access and the symbol stream
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst, ce, run, slow, rd_mark, rd_seen, train_active, train_bit, tracker_hold_n;
    logic [2:0] vsb_mode;
    logic [7:0] reg_rdata;
    eq_pkg::eq_in_s in_s;
    eq_pkg::eq_reg_req_s reg_req;
    eq_pkg::eq_out_s out_s;
    eq_pkg::eq_adapt_e adapt_mode;
    int mismatches, total_checks, seed, n, r, nsym;
    logic [15:0] rq[$];
    logic [15:0] oq[$];
    logic [15:0] cv[4];
    logic [7:0] ti[4];
    logic [2:0] modes[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};

    eq_dfe DUT (.core_clk(core_clk), .rst(rst), .ce(ce), .in_s(in_s), .train_active(train_active),
        .train_bit(train_bit), .vsb_mode(vsb_mode), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .out_s(out_s), .tracker_hold_n(tracker_hold_n), .adapt_mode(adapt_mode));
    eq_sync_model u_src (.core_clk(core_clk), .rst(rst), .run(run), .slow(slow), .sym_in(10'sh020), .in_s(in_s));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req <= {a, d, 1'b1};
        @(negedge core_clk);
        reg_req.we <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        reg_req <= {a, 8'h00, 1'b0};
        rq.push_back({8'h00, e});
        rd_mark <= 1'b1;
        @(negedge core_clk);
        rd_mark <= 1'b0;
    endtask

    // Coefficient write: write direction first, then index, high and low bytes, then a low-high strobe
    task cwr(input logic [7:0] t, input logic [15:0] v);
        wr(8'h22, 8'h06);
        wr(8'h25, t);
        wr(8'h26, v[15:8]);
        wr(8'h27, v[7:0]);
        wr(8'h22, 8'h02);
        wr(8'h22, 8'h06);
    endtask

    // Coefficient read: one spare clock lets the latched value reach the read port
    task crd(input logic [7:0] t, input logic [15:0] v);
        wr(8'h22, 8'h04);
        wr(8'h25, t);
        wr(8'h22, 8'h00);
        @(negedge core_clk);
        rd(8'h26, v[15:8]);
        rd(8'h28, v[7:0]);
        wr(8'h22, 8'h04);
    endtask

    // Watchers take the oldest note whenever a result shows up
    always @(posedge core_clk) rd_seen <= rd_mark;
    always @(negedge core_clk) if (rd_seen) chk({8'h00, reg_rdata}, rq.pop_front());
    // Level-one input through the unity centre tap comes out sixteen symbols late
    always @(posedge core_clk) begin
        if (in_s.valid === 1'b1 && !rst) begin
            nsym++;
            oq.push_back((nsym > 16) ? 16'h0020 : 16'h0000);
        end
    end
    always @(negedge core_clk) begin
        if (out_s.valid === 1'b1) begin
            chk(out_s.sym, oq.size() ? oq.pop_front() : 16'hdead);
            chk(16'(adapt_mode), 16'(eq_pkg::EQ_ADAPT_NONE));
        end
    end

    initial begin
        seed = 83826;
        mismatches = 0;
        total_checks = 0;
        nsym = 0;
        ce = 1'b1;
        rst = 1'b1;
        run = 1'b0;
        slow = 1'b0;
        rd_mark = 1'b0;
        rd_seen = 1'b0;
        reg_req = '0;
        train_active = 1'b0;
        train_bit = 1'b0;
        vsb_mode = 3'h5;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        rd(8'h21, 8'h8b);
        rd(8'h22, 8'h04);
        rd(8'h23, 8'h80);
        rd(8'h24, 8'h10);
        rd(8'h30, 8'h00);
        // A write while the clock enable is low must not land
        ce <= 1'b0;
        wr(8'h24, 8'h55);
        ce <= 1'b1;
        rd(8'h24, 8'h10);
        for (n = 0; n < 4; n++) begin
            wr(8'h23, {n[1:0], 6'h00});
            rd(8'h23, {n[1:0], 6'h00});
            wr(8'h21, {6'h00, n[1:0]});
            rd(8'h21, {6'h00, n[1:0]});
        end
        // Both holds low from here, so no tap adapts under the host
        crd(8'h10, 16'h1000);
        crd(8'h00, 16'h0000);
        wr(8'h28, 8'h5a);
        rd(8'h28, 8'h00);
        for (n = 0; n < 4; n++) begin
            r = $random(seed);
            ti[n] = {n[1:0], r[5:0]};
            if (ti[n] == 8'h10) ti[n] = 8'h11;
            cv[n] = r[23:8];
            cwr(ti[n], cv[n]);
        end
        for (n = 0; n < 4; n++) crd(ti[n], cv[n]);
        wr(8'h21, 8'h07);
        wr(8'h21, 8'h03);
        crd(ti[0], 16'h0000);
        crd(8'h10, 16'h1000);
        // Level-one symbols with frozen unity centre tap come out delayed in every mode
        for (n = 0; n < 5; n++) begin
            vsb_mode <= modes[n];
            slow <= n[0];
            run <= 1'b1;
            repeat (40) begin
                @(negedge core_clk);
                r = $random(seed);
                train_active <= r[1];
                train_bit <= r[0];
            end
            run <= 1'b0;
            repeat (8) @(negedge core_clk);
        end
        n = 0;
        while (oq.size() != 0 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 100) mismatches++;
        // Every input symbol sat exactly on a level, so the input error stayed zero
        rd(8'h29, 8'h00);
        wr(8'h21, 8'h8b);
        rd(8'h21, 8'h8b);
        repeat (4) @(negedge core_clk);
        results;
    end
endmodule
